// *** rtl/fpcs_sequencer.sv ***
// Command-issuing sequencer for flash program and erase operations.
// What this block does
// - Program is 0xe8, data words, then 0xd0.
// - Programming starts on the last data word.
// - Ready may read 1 before closing byte.
// - New command while awaiting close flags illegal.
// - Overlapping command is flagged illegal, except status clear, suspend during erase, and program or resume once suspended.
// - Resume's 0xd0 closes a pending program.
// - Error unrecoverable after interrupted suspend-time program.
// - Reset abort makes area blank state unknown.
`timescale 1ns/1ns
`include "fpcs_regs.svh"
module fpcs_sequencer (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic data_wr_i,
    input wire logic [31:0] data_word_i,
    input wire logic data_area_i,
    output logic sequencer_ready_flag_o,
    output logic illegal_cmd_o,
    output logic error_locked_o,
    output logic suspended_o,
    output logic prog_start_o,
    output logic [31:0] prog_word_o,
    output logic prog_word_valid_o,
    output logic area_blank_unknown_o
);
    fpcs_pkg::fpcs_issue_type state_q;
    fpcs_pkg::fpcs_issue_type state_d;
    logic [7:0] words_q;
    logic [7:0] words_d;
    logic illegal_q;
    logic illegal_d;
    logic locked_q;
    logic locked_d;
    logic in_susp_prog_q;
    logic in_susp_prog_d;
    logic interrupted_q;
    logic interrupted_d;
    logic unknown_q;
    logic unknown_d;
    logic start_q;
    logic start_d;
    logic erase_q;
    logic erase_d;
    logic [31:0] word_q;
    logic [31:0] word_d;
    logic word_vld_q;
    logic word_vld_d;
    logic busy;
    logic done;
    logic [7:0] need_words;
    logic word_take;

    fpcs_busy_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .start_i(start_q),
        .erase_i(erase_q),
        .hold_i(state_q == fpcs_pkg::FPCS_SUSPENDED),
        .busy_o(busy),
        .done_o(done)
    );

    assign need_words = data_area_i ? `FPCS_DATA_WORDS : `FPCS_USER_WORDS;
    assign word_take = data_wr_i && state_q == fpcs_pkg::FPCS_PROG_DATA && !illegal_q && !locked_q
        && !(cmd_wr_i && cmd_byte_i == `FPCS_CMD_STATUS_CLEAR);

    always_comb begin
        state_d = state_q;
        words_d = words_q;
        illegal_d = illegal_q;
        locked_d = locked_q;
        in_susp_prog_d = in_susp_prog_q;
        interrupted_d = interrupted_q;
        start_d = 1'b0;
        erase_d = erase_q;
        if (cmd_wr_i && cmd_byte_i == `FPCS_CMD_STATUS_CLEAR) begin
            // A suspend-time program that was broken into cannot be cleared this way.
            if (in_susp_prog_q && interrupted_q) begin
                locked_d = 1'b1;
            end else begin
                illegal_d = 1'b0;
            end
            // Leaving a half-issued command lets the host reissue it after the clear.
            if (state_q != fpcs_pkg::FPCS_IDLE && state_q != fpcs_pkg::FPCS_SUSPENDED) begin
                state_d = in_susp_prog_q ? fpcs_pkg::FPCS_SUSPENDED : fpcs_pkg::FPCS_IDLE;
            end
        end else if (illegal_q || locked_q) begin
            // Refuse everything but status clear while the error stands.
            state_d = state_q;
        end else if (word_take) begin
            words_d = words_q + 8'h01;
            if (words_q + 8'h01 == need_words) begin
                // Starting here means ready can rise before the closing byte arrives.
                start_d = 1'b1;
                erase_d = 1'b0;
                state_d = fpcs_pkg::FPCS_PROG_CLOSE;
            end
        end else if (cmd_wr_i) begin
            unique case (state_q)
                fpcs_pkg::FPCS_IDLE, fpcs_pkg::FPCS_SUSPENDED: begin
                    if (busy && state_q == fpcs_pkg::FPCS_IDLE) begin
                        illegal_d = 1'b1;
                    end else if (cmd_byte_i == `FPCS_CMD_PROGRAM) begin
                        in_susp_prog_d = (state_q == fpcs_pkg::FPCS_SUSPENDED);
                        interrupted_d = 1'b0;
                        words_d = 8'h00;
                        state_d = fpcs_pkg::FPCS_PROG_DATA;
                    end else if (cmd_byte_i == `FPCS_CMD_ERASE
                        && state_q == fpcs_pkg::FPCS_IDLE) begin
                        state_d = fpcs_pkg::FPCS_ERASE_CLOSE;
                    end else if (cmd_byte_i == `FPCS_CMD_FINAL
                        && state_q == fpcs_pkg::FPCS_SUSPENDED) begin
                        state_d = fpcs_pkg::FPCS_IDLE;
                    end else begin
                        illegal_d = 1'b1;
                    end
                end
                fpcs_pkg::FPCS_PROG_DATA: begin
                    // A byte arriving while data words are due breaks the sequence.
                    illegal_d = 1'b1;
                end
                fpcs_pkg::FPCS_PROG_CLOSE: begin
                    if (cmd_byte_i == `FPCS_CMD_FINAL) begin
                        // A resume's 0xd0 lands here and resumes nothing.
                        state_d = in_susp_prog_q ? fpcs_pkg::FPCS_SUSPENDED
                            : fpcs_pkg::FPCS_IDLE;
                        in_susp_prog_d = 1'b0;
                    end else begin
                        interrupted_d = 1'b1;
                        illegal_d = 1'b1;
                    end
                end
                fpcs_pkg::FPCS_ERASE_CLOSE: begin
                    if (cmd_byte_i == `FPCS_CMD_FINAL) begin
                        start_d = 1'b1;
                        erase_d = 1'b1;
                        state_d = fpcs_pkg::FPCS_IDLE;
                    end else begin
                        illegal_d = 1'b1;
                        state_d = fpcs_pkg::FPCS_IDLE;
                    end
                end
            endcase
            if (cmd_byte_i == `FPCS_CMD_SUSPEND && busy && erase_q
                && state_q == fpcs_pkg::FPCS_IDLE) begin
                illegal_d = illegal_q;
                state_d = fpcs_pkg::FPCS_SUSPENDED;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= fpcs_pkg::FPCS_IDLE;
            words_q <= 8'h00;
            illegal_q <= 1'b0;
            locked_q <= 1'b0;
            in_susp_prog_q <= 1'b0;
            interrupted_q <= 1'b0;
            start_q <= 1'b0;
            erase_q <= 1'b0;
        end else begin
            state_q <= state_d;
            words_q <= words_d;
            illegal_q <= illegal_d;
            locked_q <= locked_d;
            in_susp_prog_q <= in_susp_prog_d;
            interrupted_q <= interrupted_d;
            start_q <= start_d;
            erase_q <= erase_d;
        end
    end

    // The word register holds its value between words, so a late reader still sees it.
    always_comb begin
        word_d = word_q;
        word_vld_d = 1'b0;
        if (word_take) begin
            word_d = data_word_i;
            word_vld_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word_q <= 32'h00000000;
            word_vld_q <= 1'b0;
        end else begin
            word_q <= word_d;
            word_vld_q <= word_vld_d;
        end
    end

    always_comb begin
        unknown_d = unknown_q;
        if (done) begin
            unknown_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // A reset may have cut an operation short, so blank check is not trusted.
            unknown_q <= 1'b1;
        end else begin
            unknown_q <= unknown_d;
        end
    end

    assign sequencer_ready_flag_o = !busy && !start_q;
    assign illegal_cmd_o = illegal_q || locked_q;
    assign error_locked_o = locked_q;
    assign suspended_o = (state_q == fpcs_pkg::FPCS_SUSPENDED);
    assign prog_start_o = start_q;
    assign prog_word_o = word_q;
    assign prog_word_valid_o = word_vld_q;
    assign area_blank_unknown_o = unknown_q;
endmodule : fpcs_sequencer

// *** rtl/fpcs_regs.svh ***
// Command codes, counts and timing constants of the flash command sequencer.
`ifndef FPCS_REGS_SVH
`define FPCS_REGS_SVH
`define FPCS_CMD_PROGRAM 8'he8
`define FPCS_CMD_FINAL 8'hd0
`define FPCS_CMD_ERASE 8'h20
`define FPCS_CMD_SUSPEND 8'hb0
`define FPCS_CMD_STATUS_CLEAR 8'h50
`define FPCS_USER_WORDS 8'h04
`define FPCS_DATA_WORDS 8'h01
`define FPCS_PROG_CYCLES 16'h0040
`define FPCS_ERASE_CYCLES 16'h0100
`endif

// *** rtl/fpcs_pkg.sv ***
// Types shared by the flash command sequencer files.
package fpcs_pkg;
    typedef enum logic [2:0] {
        FPCS_IDLE,
        FPCS_PROG_DATA,
        FPCS_PROG_CLOSE,
        FPCS_ERASE_CLOSE,
        FPCS_SUSPENDED
    } fpcs_issue_type;
endpackage : fpcs_pkg

// *** rtl/fpcs_busy_timer.sv ***
// Down counter that models the length of a program or erase operation.
`timescale 1ns/1ns
`include "fpcs_regs.svh"
module fpcs_busy_timer (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic erase_i,
    input wire logic hold_i,
    output logic busy_o,
    output logic done_o
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic done_q;
    logic done_d;

    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (start_i) begin
            cnt_d = erase_i ? `FPCS_ERASE_CYCLES : `FPCS_PROG_CYCLES;
        end else if (cnt_q != 16'h0000 && !hold_i) begin
            cnt_d = cnt_q - 16'h0001;
            done_d = (cnt_q == 16'h0001);
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (cnt_q != 16'h0000);
    assign done_o = done_q;
endmodule : fpcs_busy_timer

// *** test/fpcs_properties.sv ***
// Checker of the flash command sequencer port behaviour.
`timescale 1ns/1ns
module fpcs_properties (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic data_wr_i,
    input wire logic [31:0] data_word_i,
    input wire logic data_area_i,
    input wire logic sequencer_ready_flag_o,
    input wire logic illegal_cmd_o,
    input wire logic error_locked_o,
    input wire logic suspended_o,
    input wire logic prog_start_o,
    input wire logic [31:0] prog_word_o,
    input wire logic prog_word_valid_o,
    input wire logic area_blank_unknown_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_start_drops_ready:
    assert property (prog_start_o |-> !sequencer_ready_flag_o ##1 !sequencer_ready_flag_o [*8])
        else $error("ready did not stay low after start");
    a_start_one_cycle:
    assert property (prog_start_o |=> !prog_start_o) else $error("start pulse too long");
    a_illegal_sticks:
    assert property (illegal_cmd_o && !(cmd_wr_i && cmd_byte_i == 8'h50) |=> illegal_cmd_o)
        else $error("illegal flag dropped without status clear");
    a_illegal_refuses:
    assert property (illegal_cmd_o |=> !prog_start_o) else $error("operation started while illegal");
    a_locked_sticks:
    assert property (error_locked_o |=> $stable(error_locked_o)) else $error("lock cleared");
    a_word_echo:
    assert property (prog_word_valid_o |-> prog_word_o == $past(data_word_i))
        else $error("data word not passed on");
    a_blank_after_reset:
    assert property ($rose(nrst_i) |-> area_blank_unknown_o) else $error("blank state known after reset");
    a_unknown_byte:
    assert property (cmd_wr_i && !data_wr_i && cmd_byte_i == 8'hff |=> illegal_cmd_o || error_locked_o)
        else $error("unknown byte not flagged");
endmodule : fpcs_properties
bind fpcs_sequencer fpcs_properties u_chk (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .cmd_wr_i(cmd_wr_i),
    .cmd_byte_i(cmd_byte_i),
    .data_wr_i(data_wr_i),
    .data_word_i(data_word_i),
    .data_area_i(data_area_i),
    .sequencer_ready_flag_o(sequencer_ready_flag_o),
    .illegal_cmd_o(illegal_cmd_o),
    .error_locked_o(error_locked_o),
    .suspended_o(suspended_o),
    .prog_start_o(prog_start_o),
    .prog_word_o(prog_word_o),
    .prog_word_valid_o(prog_word_valid_o),
    .area_blank_unknown_o(area_blank_unknown_o)
);

// *** test/fpcs_host_model.sv ***
// Host model that writes command bytes and data words to the sequencer.
`timescale 1ns/1ns
module fpcs_host_model (
    input wire logic sys_clk_i,
    output logic cmd_wr_o,
    output logic [7:0] cmd_byte_o,
    output logic data_wr_o,
    output logic [31:0] data_word_o,
    output logic data_area_o
);
    // One thread issues every command, as a host with command interrupts masked would.
    initial begin
        cmd_wr_o = 1'b0;
        cmd_byte_o = 8'h00;
        data_wr_o = 1'b0;
        data_word_o = 32'h0;
        data_area_o = 1'b0;
    end
    task set_area(input logic a);
        data_area_o = a;
    endtask : set_area
    task send_cmd(input logic [7:0] b);
        @(negedge sys_clk_i);
        cmd_wr_o = 1'b1;
        cmd_byte_o = b;
        @(negedge sys_clk_i);
        cmd_wr_o = 1'b0;
        // A released bus shows the inverse so stale values never look fresh.
        cmd_byte_o = ~b;
    endtask : send_cmd
    task send_word(input logic [31:0] w);
        @(negedge sys_clk_i);
        data_wr_o = 1'b1;
        data_word_o = w;
        @(negedge sys_clk_i);
        data_wr_o = 1'b0;
        data_word_o = ~w;
    endtask : send_word
endmodule : fpcs_host_model

// *** test/tb.sv ***
// Self-checking bench of the flash command sequencer.
`timescale 1ns/1ns
`include "fpcs_regs.svh"
module tb;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cmd_wr, data_wr, area, rdy, ill, lock, susp, start, valid, blank;
    logic [7:0] cmd_byte;
    logic [31:0] dword, pword;
    int err_total = 0;
    int tests_run = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    fpcs_host_model host (.sys_clk_i(sys_clk_i), .cmd_wr_o(cmd_wr), .cmd_byte_o(cmd_byte),
        .data_wr_o(data_wr), .data_word_o(dword), .data_area_o(area));
    fpcs_sequencer DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_wr_i(cmd_wr),
        .cmd_byte_i(cmd_byte), .data_wr_i(data_wr), .data_word_i(dword), .data_area_i(area),
        .sequencer_ready_flag_o(rdy), .illegal_cmd_o(ill), .error_locked_o(lock),
        .suspended_o(susp), .prog_start_o(start), .prog_word_o(pword),
        .prog_word_valid_o(valid), .area_blank_unknown_o(blank));
    task print_verdict;
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task wait_ready;
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 400) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk("ready", rdy, 1);
    endtask : wait_ready
    task prog(input logic a, input int n);
        host.set_area(a);
        host.send_cmd(`FPCS_CMD_PROGRAM);
        for (int i = 0; i < n; i++) begin
            host.send_word(32'h5a00_0000 + i);
            chk("valid", valid, 1);
            chk("word", pword, 32'h5a00_0000 + i);
        end
        chk("start", start, 1);
        chk("ready low", rdy, 0);
    endtask : prog
    task t_program;
        chk("blank reset", blank, 1);
        chk("illegal reset", ill, 0);
        prog(1'b0, 4);
        wait_ready();
        @(negedge sys_clk_i);
        chk("blank done", blank, 0);
        host.send_cmd(`FPCS_CMD_FINAL);
        chk("illegal close", ill, 0);
    endtask : t_program
    task t_interrupt;
        prog(1'b1, 1);
        wait_ready();
        host.send_cmd(`FPCS_CMD_ERASE);
        chk("illegal", ill, 1);
        host.send_cmd(`FPCS_CMD_PROGRAM);
        host.send_word(32'h1);
        chk("refused", start, 0);
        host.send_cmd(`FPCS_CMD_STATUS_CLEAR);
        chk("cleared", ill, 0);
        host.send_cmd(8'hff);
        chk("unknown", ill, 1);
        host.send_cmd(`FPCS_CMD_PROGRAM);
        host.send_word(32'h2);
        chk("refused idle", start, 0);
        chk("refused word", valid, 0);
        host.send_cmd(`FPCS_CMD_STATUS_CLEAR);
        host.send_cmd(`FPCS_CMD_PROGRAM);
        host.send_cmd(`FPCS_CMD_PROGRAM);
        chk("data phase", ill, 1);
        host.send_cmd(`FPCS_CMD_STATUS_CLEAR);
        chk("recovered", ill, 0);
    endtask : t_interrupt
    task t_suspend;
        host.send_cmd(`FPCS_CMD_ERASE);
        host.send_cmd(`FPCS_CMD_FINAL);
        chk("erase start", start, 1);
        host.send_cmd(`FPCS_CMD_SUSPEND);
        chk("suspended", susp, 1);
        prog(1'b0, 4);
        host.send_cmd(`FPCS_CMD_FINAL);
        chk("no resume", susp, 1);
        chk("no illegal", ill, 0);
        prog(1'b0, 4);
        host.send_cmd(`FPCS_CMD_ERASE);
        chk("interrupted", ill, 1);
        host.send_cmd(`FPCS_CMD_STATUS_CLEAR);
        chk("locked", lock, 1);
    endtask : t_suspend
    task t_abort;
        @(negedge sys_clk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        chk("lock reset", lock, 0);
        prog(1'b1, 1);
        nrst_i = 1'b0;
        @(negedge sys_clk_i);
        nrst_i = 1'b1;
        chk("blank abort", blank, 1);
        host.send_cmd(`FPCS_CMD_ERASE);
        host.send_cmd(`FPCS_CMD_FINAL);
        host.send_cmd(`FPCS_CMD_SUSPEND);
        chk("abort susp", susp, 1);
        host.send_cmd(`FPCS_CMD_FINAL);
        chk("resumed", susp, 0);
        wait_ready();
        @(negedge sys_clk_i);
        chk("blank erased", blank, 0);
    endtask : t_abort
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (8) @(negedge sys_clk_i);
        nrst_i = 1'b1;
        t_program();
        t_interrupt();
        t_suspend();
        t_abort();
        print_verdict();
    end
endmodule : tb
